// File: ers_map.svh
// Offsets, field positions, factory values and widths for the region selector
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH

// ============================================================
// Register byte offsets on the bus
`define ERS_OFF_GLOBAL 8'h00
`define ERS_OFF_PTR1 8'h04
`define ERS_OFF_PTR2 8'h08
`define ERS_OFF_PTR3 8'h0C
`define ERS_OFF_PTR4 8'h10
`define ERS_OFF_PROBE 8'h14

// ============================================================
// Pointer register fields
`define ERS_PTR_W 11
`define ERS_PTR_SECTOR_MSB 10
`define ERS_PTR_SECTOR_LSB 2
`define ERS_PTR_TYPE_BIT 1
`define ERS_PTR_EN_N_BIT 0

// ============================================================
// Global register fields
`define ERS_GLB_W 2
`define ERS_GLB_TYPE_BIT 1
`define ERS_GLB_WEAR_BIT 0

// ============================================================
// Probe register fields
`define ERS_PROBE_SECTOR_MSB 8
`define ERS_PROBE_TYPE_BIT 16
`define ERS_PROBE_IDX_LSB 17
`define ERS_PROBE_IDX_MSB 19

// ============================================================
// Factory values of the nonvolatile fields
`define ERS_PTR_DEFAULT 11'h7FF
`define ERS_GLB_DEFAULT 2'h3

`endif

// File: ers_pkg.sv
// Shared types of the endurance region selector
package ers_pkg;

  // ============================================================
  // Sector number and region kinds
  typedef logic [8:0] ers_sector_t;     // Sector address
  typedef logic [2:0] ers_index_t;      // 0 = global, 1..4 = pointer

  typedef enum logic {
    ERS_LONG_RETENTION,
    ERS_HIGH_ENDURANCE
  } ers_region_t;

endpackage : ers_pkg

// File: ers_resolve.sv
// Finds the region governing one sector from the four pointers
`timescale 1ns/10ps
`include "ers_map.svh"

module ers_resolve #(
  parameter int NUM_PTR = 4,
  parameter int SECTOR_W = 9
) (
  input wire logic [NUM_PTR*`ERS_PTR_W-1:0] ptrFlat, // Pointer words, pointer one lowest
  input wire logic globalRegionType,                  // Type when no pointer governs
  input wire logic [SECTOR_W-1:0] sector,             // Sector to classify
  output ers_pkg::ers_region_t regionType,            // Resolved type
  output ers_pkg::ers_index_t regionIndex,            // Governing pointer, 0 for global
  output logic [SECTOR_W-1:0] regionStart             // First sector of that region
);

  // ============================================================
  // Search for the enabled pointer with the highest start not above the sector
  always_comb begin
    logic found;
    logic [`ERS_PTR_W-1:0] word;
    found = 1'b0;
    word = '0;
    regionStart = '0;
    regionIndex = 3'h0;
    regionType = ers_pkg::ers_region_t'(globalRegionType);
    for (int i = 0; i < NUM_PTR; i++) begin
      word = ptrFlat[i*`ERS_PTR_W +: `ERS_PTR_W];
      if (!word[`ERS_PTR_EN_N_BIT] &&
          word[`ERS_PTR_SECTOR_MSB:`ERS_PTR_SECTOR_LSB] <= sector &&
          (!found || word[`ERS_PTR_SECTOR_MSB:`ERS_PTR_SECTOR_LSB] >= regionStart)) begin
        // Equal starts: the higher pointer wins
        found = 1'b1;
        regionStart = word[`ERS_PTR_SECTOR_MSB:`ERS_PTR_SECTOR_LSB];
        regionIndex = 3'(i + 1);
        regionType = ers_pkg::ers_region_t'(word[`ERS_PTR_TYPE_BIT]);
      end
    end
  end

endmodule : ers_resolve

// File: ers_top.sv
// Endurance region selector: nonvolatile pointers, Wishbone slave, sector classifier
// Summary of operation
// - Pointer bits 10:2 hold region start sector
// - Pointer bit 1 picks retention or endurance
// - Pointer bit 0 low enables the pointer
// - Global type governs when no pointer enabled
// - Global bit 0 switches wear leveling
// - Pointer and global fields survive resets as nonvolatile
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "ers_map.svh"

module ers_top #(
  parameter int NUM_PTR = 4,  // Number of region pointers
  parameter int ADR_W = 8     // Byte address width
) (
  input wire logic core_clk,                   // 40 MHz clock
  input wire logic rstn,                       // Asynchronous reset, active low
  input wire logic wb_cyc_i,                   // Bus cycle
  input wire logic wb_stb_i,                   // Bus strobe
  input wire logic wb_we_i,                    // Write enable
  input wire logic [ADR_W-1:0] wb_adr_i,       // Byte address
  input wire logic [3:0] wb_sel_i,             // Byte lanes
  input wire logic [31:0] wb_dat_i,            // Write data
  output logic [31:0] wb_dat_o,                // Read data
  output logic wb_ack_o,                       // Acknowledge
  input wire ers_pkg::ers_sector_t querySector, // Sector from the array logic
  output ers_pkg::ers_region_t regionType,     // Type of queried sector
  output ers_pkg::ers_index_t regionIndex,     // Pointer governing it
  output logic wearLevelEnable                 // Wear leveling switch
);

  // ============================================================
  // Reset release synchroniser
  logic rstMeta;    // First stage, read only by second
  logic rstSyncN;   // Released reset used everywhere

  // Two stages so release never lands mid-setup
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // ============================================================
  // Nonvolatile storage
  // These flops start at the factory value and are never touched by reset,
  // standing in for the flash cells behind them.
  logic [`ERS_PTR_W-1:0] ptrReg [NUM_PTR] = '{default: `ERS_PTR_DEFAULT};
  logic [`ERS_GLB_W-1:0] glbReg = `ERS_GLB_DEFAULT;
  logic [NUM_PTR*`ERS_PTR_W-1:0] ptrFlat;  // Packed copy for the resolvers
  logic [NUM_PTR-1:0] ptrEnN;              // Enable-low bits of all pointers

  // Pack pointer words for the resolver ports
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      ptrFlat[i*`ERS_PTR_W +: `ERS_PTR_W] = ptrReg[i];
      ptrEnN[i] = ptrReg[i][`ERS_PTR_EN_N_BIT];
    end
  end

  // ============================================================
  // Bus decode
  logic busReq;     // Request waiting for its answer
  logic busWrite;   // Write taken this cycle
  logic hitGlobal;  // Global register addressed
  logic hitProbe;   // Probe register addressed
  logic [NUM_PTR-1:0] hitPtr;  // Pointer register addressed

  // One request per ack; the high ack blocks a double take
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite = busReq && wb_we_i;
  assign hitGlobal = (wb_adr_i == `ERS_OFF_GLOBAL);
  assign hitProbe = (wb_adr_i == `ERS_OFF_PROBE);

  // Pointer n sits one word above pointer n-1
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      hitPtr[i] = (wb_adr_i == ADR_W'(`ERS_OFF_PTR1 + 4 * i));
    end
  end

  // ============================================================
  // Acknowledge: one cycle after the strobe, dropped the next cycle
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // ============================================================
  // Pointer register writes
  // no reset on stored fields
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_PTR; i++) begin
      if (rstSyncN && busWrite && hitPtr[i]) begin
        // Low byte: sector low bits, type, enable
        if (wb_sel_i[0]) begin
          ptrReg[i][7:0] <= wb_dat_i[7:0];
        end
        // Second byte: top sector bits
        if (wb_sel_i[1]) begin
          ptrReg[i][`ERS_PTR_W-1:8] <= wb_dat_i[`ERS_PTR_W-1:8];
        end
      end
    end
  end

  // ============================================================
  // Global register write
  // survives reset
  always_ff @(posedge core_clk) begin
    if (rstSyncN && busWrite && hitGlobal && wb_sel_i[0]) begin
      glbReg <= wb_dat_i[`ERS_GLB_W-1:0];
    end
  end

  // ============================================================
  // Probe sector: software picks a sector to classify
  ers_pkg::ers_sector_t probeSector;  // Volatile, cleared by reset

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      probeSector <= '0;
    end else if (busWrite && hitProbe) begin
      if (wb_sel_i[0]) begin
        probeSector[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        probeSector[8] <= wb_dat_i[8];
      end
    end
  end

  // ============================================================
  // Two classifiers: the array port and the software probe
  ers_pkg::ers_region_t portType;   // Port result, before the output flop
  ers_pkg::ers_index_t portIdx;     // Port governing pointer
  ers_pkg::ers_sector_t portStart;  // Port region start
  ers_pkg::ers_region_t probeType;  // Probe result
  ers_pkg::ers_index_t probeIdx;    // Probe governing pointer

  ers_resolve #(
    .NUM_PTR(NUM_PTR),
    .SECTOR_W(9)
  ) u_port_resolve (
    .ptrFlat(ptrFlat),
    .globalRegionType(glbReg[`ERS_GLB_TYPE_BIT]),
    .sector(querySector),
    .regionType(portType),
    .regionIndex(portIdx),
    .regionStart(portStart)
  );

  ers_resolve #(
    .NUM_PTR(NUM_PTR),
    .SECTOR_W(9)
  ) u_probe_resolve (
    .ptrFlat(ptrFlat),
    .globalRegionType(glbReg[`ERS_GLB_TYPE_BIT]),
    .sector(probeSector),
    .regionType(probeType),
    .regionIndex(probeIdx),
    .regionStart()
  );

  // ============================================================
  // Registered classifier outputs
  // One cycle of latency buys clean outputs at the cost of a stale cycle
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      regionType <= ers_pkg::ERS_LONG_RETENTION;
      regionIndex <= 3'h0;
    end else begin
      regionType <= portType;
      regionIndex <= portIdx;
    end
  end

  // ============================================================
  // Wear leveling switch
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wearLevelEnable <= 1'b0;
    end else begin
      wearLevelEnable <= glbReg[`ERS_GLB_WEAR_BIT];
    end
  end

  // ============================================================
  // Read data mux
  logic [31:0] next_datO;  // Read word for the next ack

  always_comb begin
    next_datO = 32'h0000_0000;
    if (hitGlobal) begin
      next_datO[`ERS_GLB_W-1:0] = glbReg;
    end else if (hitProbe) begin
      // Sector plus its live classification
      next_datO[`ERS_PROBE_SECTOR_MSB:0] = probeSector;
      next_datO[`ERS_PROBE_TYPE_BIT] = probeType;
      next_datO[`ERS_PROBE_IDX_MSB:`ERS_PROBE_IDX_LSB] = probeIdx;
    end else begin
      // Pointer words, unmapped stays zero
      for (int i = 0; i < NUM_PTR; i++) begin
        if (hitPtr[i]) begin
          next_datO[`ERS_PTR_W-1:0] = ptrReg[i];
        end
      end
    end
  end

  // Read data only changes with a taken request
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq) begin
      wb_dat_o <= next_datO;
    end
  end

  // ============================================================
  // Checks
  // Classifier and bus outputs hold reset values on the release edge,
  // so the output checks only start on an edge where reset was already off.
  // Armed one edge in, so the stability check always has a history
  logic chkArmed = 1'b0;  // Assertion helper, never reset

  always_ff @(posedge core_clk) begin
    chkArmed <= 1'b1;
  end

  sequence sWrPtr1;
    busWrite && hitPtr[0] && (wb_sel_i[1:0] == 2'h3);
  endsequence

  sequence sWrGlobal;
    busWrite && hitGlobal && wb_sel_i[0];
  endsequence

  sequence sRdGlobal;
    rstSyncN && busReq && !wb_we_i && hitGlobal;
  endsequence

  sequence sRdPtr1;
    rstSyncN && busReq && !wb_we_i && hitPtr[0];
  endsequence

  chk_sector_field: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    sWrPtr1 |=> ptrReg[0][`ERS_PTR_SECTOR_MSB:`ERS_PTR_SECTOR_LSB] ==
      $past(wb_dat_i[`ERS_PTR_SECTOR_MSB:`ERS_PTR_SECTOR_LSB]))
    else $error("pointer sector field not stored");

  chk_type_follows: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    rstSyncN && (portIdx == 3'h1) |=> regionType == ers_pkg::ers_region_t'($past(ptrReg[0][`ERS_PTR_TYPE_BIT])))
    else $error("region type does not follow pointer bit");

  chk_enable_low: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    (portIdx != 3'h0) |-> !ptrEnN[2'(portIdx - 3'h1)])
    else $error("disabled pointer governs a sector");

  chk_global_all: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    rstSyncN && (&ptrEnN) |=> (regionIndex == 3'h0) &&
      (regionType == ers_pkg::ers_region_t'($past(glbReg[`ERS_GLB_TYPE_BIT]))))
    else $error("global type not applied with all pointers off");

  chk_wear_write: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    sWrGlobal ##1 1'b1 |=> wearLevelEnable == $past(wb_dat_i[`ERS_GLB_WEAR_BIT], 2))
    else $error("wear leveling switch not updated");

  // No disable here: the point is to watch the fields while reset holds
  chk_nv_survive: assert property (
    @(posedge core_clk)
    chkArmed && !rstSyncN |-> $stable(ptrFlat) && $stable(glbReg))
    else $error("stored fields changed across reset");

  chk_region_span: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    (portIdx != 3'h0) |-> (portStart <= querySector))
    else $error("sector below its region start");

  chk_ack_pulse: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_answer: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    rstSyncN && busReq |=> wb_ack_o)
    else $error("taken request got no ack");

  chk_read_global: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    sRdGlobal |=> wb_dat_o == 32'($past(glbReg)))
    else $error("global register read wrong");

  chk_read_pointer: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    sRdPtr1 |=> wb_dat_o == 32'($past(ptrReg[0])))
    else $error("pointer register read wrong");

  chk_wear_level: assert property (
    @(posedge core_clk) disable iff (!rstSyncN)
    rstSyncN |=> wearLevelEnable == $past(glbReg[`ERS_GLB_WEAR_BIT]))
    else $error("wear leveling switch not following bit 0");

endmodule : ers_top

// File: ers_top_tb.sv
// Self-checking bench for the endurance region selector, register bus and classifier
`timescale 1ns/10ps
`include "ers_map.svh"

// ============================================================
// Compare helper, counts every check and reports a mismatch
`define CHECK_EQ(what, expv, gotv) begin \
  totalChecks++; \
  if ((gotv) !== (expv)) begin \
    errorCnt++; \
    $display("MISMATCH %s expected %0h seen %0h", what, expv, gotv); \
  end \
end

module ers_top_tb_top;
  // ============================================================
  // Signals
  logic core_clk;                        // Bench clock, 40 MHz
  logic rstn;                            // Reset, active low
  logic wbCyc;                           // Bus cycle
  logic wbStb;                           // Bus strobe
  logic wbWe;                            // Write enable
  logic [7:0] wbAdr;                     // Byte address
  logic [3:0] wbSel;                     // Byte lanes
  logic [31:0] wbDatI;                   // Write data
  logic [31:0] wbDatO;                   // Read data
  logic wbAck;                           // Acknowledge
  ers_pkg::ers_sector_t querySector;     // Sector under test
  ers_pkg::ers_region_t regionType;      // Classified type
  ers_pkg::ers_index_t regionIndex;      // Governing pointer
  logic wearLevelEnable;                 // Wear switch
  logic [10:0] shadowPtr [1:4];          // Expected pointer words
  logic [1:0] shadowGlb;                 // Expected global word
  int errorCnt;                          // Mismatch count
  int totalChecks;                       // Comparison count
  logic [31:0] rd;                       // Scratch read value
  logic [3:0] ev;                        // Scratch expectation
  // Boundary sectors around every pointer start
  logic [8:0] sectors [10] = '{9'h000, 9'h009, 9'h00A, 9'h01D, 9'h01E, 9'h031, 9'h032, 9'h063, 9'h064, 9'h1FF};
  // Start 10 HE on, start 30 HE off, start 50 LR on, start 100 HE on
  logic [10:0] ptrVals [1:4] = '{11'h02A, 11'h07B, 11'h0C8, 11'h192};

  ers_top ers_top_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .querySector(querySector),
    .regionType(regionType),
    .regionIndex(regionIndex),
    .wearLevelEnable(wearLevelEnable)
  );

  // ============================================================
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ============================================================
  // Reference resolution: {type, index}; ascending scan lets the higher pointer win ties
  function automatic logic [3:0] expRegion(input logic [8:0] s);
    logic [3:0] r;
    logic [8:0] best;
    r = {shadowGlb[1], 3'h0};
    best = 9'h000;
    for (int i = 1; i <= 4; i++) begin
      if (shadowPtr[i][0] == 1'b0 && shadowPtr[i][10:2] <= s && (r[2:0] == 3'h0 || shadowPtr[i][10:2] >= best)) begin
        r = {shadowPtr[i][1], 3'(i)};
        best = shadowPtr[i][10:2];
      end
    end
    return r;
  endfunction : expRegion

  // ============================================================
  // Verdict, the only place the run ends
  task automatic finalReport;
    $display("Checks %0d, mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finalReport

  // Classic single cycle; request held until ack is sampled high, then released
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    bit got;
    got = 1'b0;
    rdat = 32'h0;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= wdat;
    for (int n = 0; n < 16 && !got; n++) begin
      @(posedge core_clk);
      if (wbAck === 1'b1) begin
        got = 1'b1;
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
      end
    end
    if (!got) begin
      errorCnt++;
      $display("MISMATCH ack expected 1 seen 0");
      finalReport();
    end
  endtask : wbXfer

  // Write that also tracks the expected register image
  task automatic wbWrite(input logic [7:0] adr, input logic [31:0] wdat);
    logic [31:0] unused;
    wbXfer(1'b1, adr, wdat, unused);
    if (adr == `ERS_OFF_GLOBAL) shadowGlb = wdat[1:0];
    if (adr >= `ERS_OFF_PTR1 && adr <= `ERS_OFF_PTR4 && adr[1:0] == 2'h0) shadowPtr[adr[4:2]] = wdat[10:0];
  endtask : wbWrite

  // Read global and pointer registers against the image; wear switch too
  task automatic readAll;
    wbXfer(1'b0, `ERS_OFF_GLOBAL, 32'h0, rd);
    `CHECK_EQ("global reg", {30'h0, shadowGlb}, rd)
    for (int i = 1; i <= 4; i++) begin
      wbXfer(1'b0, 8'(i * 4), 32'h0, rd);
      `CHECK_EQ("pointer reg", {21'h0, shadowPtr[i]}, rd)
    end
    `CHECK_EQ("wear level", shadowGlb[0], wearLevelEnable)
  endtask : readAll

  // Back-to-back queries, one sector each cycle, answer one cycle later
  task automatic sweep;
    for (int i = 0; i <= 10; i++) begin
      @(posedge core_clk);
      if (i < 10) querySector <= sectors[i];
      #1;
      if (i > 0) begin
        ev = expRegion(sectors[i-1]);
        `CHECK_EQ("region type", ev[3], logic'(regionType))
        `CHECK_EQ("region index", ev[2:0], regionIndex)
      end
    end
  endtask : sweep

  // ============================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    querySector = 9'h000;
    errorCnt = 0;
    totalChecks = 0;
    // Factory image of the unreset fields
    shadowGlb = `ERS_GLB_DEFAULT;
    for (int i = 1; i <= 4; i++) shadowPtr[i] = `ERS_PTR_DEFAULT;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    readAll();
    sweep();
    $display("Test factory done");
    wbWrite(`ERS_OFF_GLOBAL, 32'h0);
    @(posedge core_clk);
    #1;
    readAll();
    sweep();
    $display("Test global done");
    for (int i = 1; i <= 4; i++) wbWrite(8'(i * 4), {21'h0, ptrVals[i]});
    readAll();
    sweep();
    // Equal starts, pointer three outranks pointer two
    wbWrite(`ERS_OFF_PTR2, 32'h0CA);
    sweep();
    $display("Test pointers done");
    // probe reports type and index of a sector
    for (int i = 0; i < 10; i += 3) begin
      wbWrite(`ERS_OFF_PROBE, {23'h0, sectors[i]});
      wbXfer(1'b0, `ERS_OFF_PROBE, 32'h0, rd);
      ev = expRegion(sectors[i]);
      `CHECK_EQ("probe", {12'h0, ev[2:0], ev[3], 7'h0, sectors[i]}, rd)
    end
    $display("Test probe done");
    // Unmapped place reads zero and ignores writes
    wbXfer(1'b0, 8'h18, 32'h0, rd);
    `CHECK_EQ("unmapped read", 32'h0, rd)
    wbWrite(8'h18, 32'h0000_0003);
    readAll();
    $display("Test unmapped done");
    // settings survive a reset in mid-run
    wbWrite(`ERS_OFF_GLOBAL, 32'h3);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    readAll();
    sweep();
    $display("Test reset done");
    finalReport();
  end
endmodule : ers_top_tb_top
